// [src/epic_ctrl.sv]
// External pin interrupt controller: registers, flags, vector requests.
// Notes on behaviour
// - Vector B is enabled only by mask bit 7 together with global enable.
// - Vector A is enabled only by mask bit 6 together with global enable.
// - Each dedicated pin has a two-bit sense field in the control register.
// - Sense 00 is low level, 01 any change, 10 falling, 11 rising edge.
// - In level mode an enabled pin requests for as long as it stays low.
// - Pin activity is seen even when the pin is driven as an output.
// - Pin change requests need mask bit 5 and global enable.
// - Each of the three sources has its own vector request line.
// - Flag bit 7 is set when the second dedicated pin raises a request.
// - Flag bit 6 is set when the first dedicated pin raises a request.
// - Flag bit 5 is set when an enabled pin change input toggles.
// - A vector is requested when its flag, its enable and global enable hold.
// - The CPU entering a routine clears that source's flag.
// - Writing one clears a flag and writing zero leaves it alone.
// - A dedicated pin in level mode keeps its flag cleared.
// - Each pin change mask bit enables change detection on its own input.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module epic_ctrl
   import epic_pkg::*;
#(
   parameter int PC_W = 8
)
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              ce,
   input  wire logic              ext_irq_a,
   input  wire logic              ext_irq_b,
   input  wire logic [PC_W-1:0]   pin_change_inputs,
   input  wire logic              global_int_en,
   input  wire logic              ack_vec_a,
   input  wire logic              ack_vec_b,
   input  wire logic              ack_vec_pc,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata_q,
   output logic                   irq_vec_a_q,
   output logic                   irq_vec_b_q,
   output logic                   irq_vec_pc_q
);

   // ***********************************************************
   // Declarations.
   // ***********************************************************
   logic [DATA_W-1:0] gimask_q;
   logic [PC_W-1:0]   pcmask_q;
   logic [SNS_W-1:0]  sense_q;
   logic              flag_a_q;
   logic              flag_a_d;
   logic              flag_b_q;
   logic              flag_b_d;
   logic              flag_pc_q;
   logic              flag_pc_d;
   logic [DED_W-1:0]  ded_now;
   logic [DED_W-1:0]  ded_rise;
   logic [DED_W-1:0]  ded_fall;
   logic [PC_W-1:0]   pc_now;
   logic [PC_W-1:0]   pc_rise;
   logic [PC_W-1:0]   pc_fall;
   logic [1:0]        sense_a;
   logic [1:0]        sense_b;
   logic              evt_a;
   logic              evt_b;
   logic              evt_pc;
   logic              wr_flags;
   logic              en_a;
   logic              en_b;
   logic              en_pc;
   logic              req_a;
   logic              req_b;
   logic              req_pc;

   // ***********************************************************
   // Pin sampling.
   // ***********************************************************
   // The pins are watched straight from the pad side, so a pin
   // that the port drives still reaches the detectors.
   epic_pin_watch #(.W(DED_W)) u_ded_watch (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .pins    ({ext_irq_b, ext_irq_a}),
      .now_q   (ded_now),
      .rise    (ded_rise),
      .fall    (ded_fall)
   );

   epic_pin_watch #(.W(PC_W)) u_pc_watch (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .pins    (pin_change_inputs),
      .now_q   (pc_now),
      .rise    (pc_rise),
      .fall    (pc_fall)
   );

   // ***********************************************************
   // Sense decoding.
   // ***********************************************************
   // Returns the edge event selected by a sense field; level mode
   // gives no event because it never latches a flag.
   function automatic logic sense_evt(
      input logic [1:0] mode,
      input logic       r,
      input logic       f
   );
      logic hit;
      hit = 1'b0;
      case (mode)
         SENSE_ANY:  hit = r | f;
         SENSE_FALL: hit = f;
         SENSE_RISE: hit = r;
         default:    hit = 1'b0;
      endcase
      return hit;
   endfunction : sense_evt

   // Sense fields sit in the control register, one per pin.
   assign sense_a = sense_q[SNS_A_LO +: 2];
   assign sense_b = sense_q[SNS_B_LO +: 2];
   assign evt_a   = sense_evt(sense_a, ded_rise[0], ded_fall[0]);
   assign evt_b   = sense_evt(sense_b, ded_rise[1], ded_fall[1]);

   // A masked-off input cannot contribute a change.
   assign evt_pc  = |((pc_rise | pc_fall) & pcmask_q);

   // ***********************************************************
   // Register writes.
   // ***********************************************************
   assign wr_flags = reg_wr && (reg_addr == OFF_FLAGS);

   // Mask and control registers; the flag register is not stored
   // here since its bits only clear on write.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         gimask_q <= RST_REG;
         pcmask_q <= PC_W'(RST_REG);
         sense_q  <= RST_SNS;
      end
      else if (ce && reg_wr)
      begin
         if (reg_addr == OFF_GIMASK)
         begin
            gimask_q <= reg_wdata;
         end
         else if (reg_addr == OFF_PCMASK)
         begin
            pcmask_q <= reg_wdata[PC_W-1:0];
         end
         else if (reg_addr == OFF_MCUCTL)
         begin
            sense_q <= reg_wdata[SNS_W-1:0];
         end
      end
   end

   // ***********************************************************
   // Pending flags.
   // ***********************************************************
   // A new event beats a clear in the same cycle so that no
   // request is lost; level mode forces the flag low outright.
   always_comb
   begin
      flag_a_d = flag_a_q;
      if (sense_a == SENSE_LOW)
         flag_a_d = 1'b0;
      else if (evt_a)
         flag_a_d = 1'b1;
      else if (ack_vec_a || (wr_flags && reg_wdata[BIT_A]))
         flag_a_d = 1'b0;
   end

   always_comb
   begin
      flag_b_d = flag_b_q;
      if (sense_b == SENSE_LOW)
         flag_b_d = 1'b0;
      else if (evt_b)
         flag_b_d = 1'b1;
      else if (ack_vec_b || (wr_flags && reg_wdata[BIT_B]))
         flag_b_d = 1'b0;
   end

   always_comb
   begin
      flag_pc_d = flag_pc_q;
      if (evt_pc)
         flag_pc_d = 1'b1;
      else if (ack_vec_pc || (wr_flags && reg_wdata[BIT_PC]))
         flag_pc_d = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         flag_a_q  <= RST_BIT;
         flag_b_q  <= RST_BIT;
         flag_pc_q <= RST_BIT;
      end
      else if (ce)
      begin
         flag_a_q  <= flag_a_d;
         flag_b_q  <= flag_b_d;
         flag_pc_q <= flag_pc_d;
      end
   end

   // ***********************************************************
   // Vector requests.
   // ***********************************************************
   assign en_a   = gimask_q[BIT_A] && global_int_en;
   assign en_b   = gimask_q[BIT_B] && global_int_en;
   assign en_pc  = gimask_q[BIT_PC] && global_int_en;

   // Level mode follows the sampled pin, so the request drops as
   // soon as the pin returns high, whatever the CPU has done.
   assign req_a  = en_a && ((sense_a == SENSE_LOW) ? !ded_now[0]
                                                   : flag_a_q);
   assign req_b  = en_b && ((sense_b == SENSE_LOW) ? !ded_now[1]
                                                   : flag_b_q);
   assign req_pc = en_pc && flag_pc_q;

   // One line per vector, registered for a clean output.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         irq_vec_a_q  <= RST_BIT;
         irq_vec_b_q  <= RST_BIT;
         irq_vec_pc_q <= RST_BIT;
      end
      else if (ce)
      begin
         irq_vec_a_q  <= req_a;
         irq_vec_b_q  <= req_b;
         irq_vec_pc_q <= req_pc;
      end
   end

   // ***********************************************************
   // Register reads.
   // ***********************************************************
   // Unmapped offsets and unused flag and control bits read as zero; unused mask bits read back as written.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         reg_rdata_q <= RST_REG;
      else if (ce)
      begin
         reg_rdata_q <= RST_REG;
         if (reg_rd)
         begin
            if (reg_addr == OFF_GIMASK)
               reg_rdata_q <= gimask_q;
            else if (reg_addr == OFF_FLAGS)
            begin
               reg_rdata_q         <= RST_REG;
               reg_rdata_q[BIT_B]  <= flag_b_q;
               reg_rdata_q[BIT_A]  <= flag_a_q;
               reg_rdata_q[BIT_PC] <= flag_pc_q;
            end
            else if (reg_addr == OFF_PCMASK)
               reg_rdata_q <= DATA_W'(pcmask_q);
            else if (reg_addr == OFF_MCUCTL)
               reg_rdata_q <= DATA_W'(sense_q);
         end
      end
   end

   // ***********************************************************
   // Assertions.
   // ***********************************************************
   sequence s_a_low_armed;
      ce && en_a && (sense_a == SENSE_LOW) && !ded_now[0];
   endsequence

   sequence s_pc_clear_only;
      ce && !evt_pc && (ack_vec_pc || (wr_flags && reg_wdata[BIT_PC]));
   endsequence

   property p_gate_a;
      @(posedge clk) disable iff (!reset_n)
      ce && !(gimask_q[BIT_A] && global_int_en) |=> !irq_vec_a_q;
   endproperty
   a_gate_a: assert property (p_gate_a)
      else $error("vector A raised without its enables");

   property p_gate_b;
      @(posedge clk) disable iff (!reset_n)
      ce && !(gimask_q[BIT_B] && global_int_en) |=> !irq_vec_b_q;
   endproperty
   a_gate_b: assert property (p_gate_b)
      else $error("vector B raised without its enables");

   property p_gate_pc;
      @(posedge clk) disable iff (!reset_n)
      ce && !en_pc |=> !irq_vec_pc_q;
   endproperty
   a_gate_pc: assert property (p_gate_pc)
      else $error("pin change vector raised while disabled");

   property p_level_a;
      @(posedge clk) disable iff (!reset_n)
      s_a_low_armed |=> irq_vec_a_q;
   endproperty
   a_level_a: assert property (p_level_a)
      else $error("low level on pin A did not request");

   property p_level_flag;
      @(posedge clk) disable iff (!reset_n)
      ce && (sense_b == SENSE_LOW) |=> !flag_b_q;
   endproperty
   a_level_flag: assert property (p_level_flag)
      else $error("flag B set while in level mode");

   property p_fall_a;
      @(posedge clk) disable iff (!reset_n)
      ce && (sense_a == SENSE_FALL) && ded_fall[0] |=> flag_a_q;
   endproperty
   a_fall_a: assert property (p_fall_a)
      else $error("falling edge on pin A not flagged");

   property p_rise_b;
      @(posedge clk) disable iff (!reset_n)
      ce && (sense_b == SENSE_RISE) && ded_rise[1] |=> flag_b_q;
   endproperty
   a_rise_b: assert property (p_rise_b)
      else $error("rising edge on pin B not flagged");

   property p_pc_clear;
      @(posedge clk) disable iff (!reset_n)
      s_pc_clear_only |=> !flag_pc_q;
   endproperty
   a_pc_clear: assert property (p_pc_clear)
      else $error("pin change flag not cleared");

   property p_pc_masked;
      @(posedge clk) disable iff (!reset_n)
      ce && (pcmask_q == '0) && !flag_pc_q |=> !flag_pc_q;
   endproperty
   a_pc_masked: assert property (p_pc_masked)
      else $error("pin change flag set with all inputs masked");

   property p_pc_vector;
      @(posedge clk) disable iff (!reset_n)
      ce && en_pc && flag_pc_q |=> irq_vec_pc_q;
   endproperty
   a_pc_vector: assert property (p_pc_vector)
      else $error("pending pin change not requested");

   property p_write_zero;
      @(posedge clk) disable iff (!reset_n)
      ce && wr_flags && !reg_wdata[BIT_PC] && !ack_vec_pc && flag_pc_q
      |=> flag_pc_q;
   endproperty
   a_write_zero: assert property (p_write_zero)
      else $error("writing zero cleared the pin change flag");

endmodule : epic_ctrl

// [shared/epic_pkg.sv]
// Constants shared by the external pin interrupt controller files.
package epic_pkg;

   // ***********************************************************
   // Widths.
   // ***********************************************************
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 3;
   localparam int          DED_W         = 2;

   // ***********************************************************
   // Register offsets.
   // ***********************************************************
   localparam logic [2:0]  OFF_GIMASK    = 3'h0;
   localparam logic [2:0]  OFF_FLAGS     = 3'h1;
   localparam logic [2:0]  OFF_PCMASK    = 3'h2;
   localparam logic [2:0]  OFF_MCUCTL    = 3'h3;

   // ***********************************************************
   // Field positions in the mask, flag and control registers.
   // ***********************************************************
   localparam int          BIT_B         = 7;
   localparam int          BIT_A         = 6;
   localparam int          BIT_PC        = 5;
   localparam int          SNS_A_LO      = 0;
   localparam int          SNS_B_LO      = 2;
   localparam int          SNS_W         = 4;

   // ***********************************************************
   // Reset values.
   // ***********************************************************
   localparam logic [7:0]  RST_REG       = 8'h00;
   localparam logic [3:0]  RST_SNS       = 4'h0;
   localparam logic        RST_BIT       = 1'b0;
   localparam logic        PIN_IDLE      = 1'b1;

   // ***********************************************************
   // Sense control codes.
   // ***********************************************************
   localparam logic [1:0]  SENSE_LOW     = 2'h0;
   localparam logic [1:0]  SENSE_ANY     = 2'h1;
   localparam logic [1:0]  SENSE_FALL    = 2'h2;
   localparam logic [1:0]  SENSE_RISE    = 2'h3;

endpackage : epic_pkg

// [src/epic_pin_watch.sv]
// Pin sampler with previous-sample edge and change detection.
`timescale 1ns/10ps
module epic_pin_watch
   import epic_pkg::*;
#(
   parameter int W = 8
)
(
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          ce,
   input  wire logic [W-1:0]  pins,
   output logic      [W-1:0]  now_q,
   output logic      [W-1:0]  rise,
   output logic      [W-1:0]  fall
);

   // ***********************************************************
   // Sample registers.
   // ***********************************************************
   logic [W-1:0] prev_q;

   // Reset to idle high so a quiet pin shows no low level.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         now_q  <= {W{PIN_IDLE}};
         prev_q <= {W{PIN_IDLE}};
      end
      else if (ce)
      begin
         now_q  <= pins;
         prev_q <= now_q;
      end
   end

   // Edges compare the current sample against the one before.
   assign rise = now_q & ~prev_q;
   assign fall = ~now_q & prev_q;

endmodule : epic_pin_watch

// [tb/epic_pin_cpu_model.sv]
// Partner model: external pin drivers and CPU vector acknowledge logic.
`timescale 1ns/10ps
module epic_pin_cpu_model
   import epic_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       ack_en,
   input  wire logic [3:0] ack_dly,
   input  wire logic       irq_vec_a_q,
   input  wire logic       irq_vec_b_q,
   input  wire logic       irq_vec_pc_q,
   output logic            ext_irq_a,
   output logic            ext_irq_b,
   output logic [7:0]      pin_change_inputs,
   output logic [2:0]      ack_vec
);
   logic [4:0] wait_q [3];
   logic [7:0] ack_cnt [3];
   logic [2:0] req;

   // Pins idle high so no event is seen while reset is released.
   initial
   begin
      ext_irq_a = PIN_IDLE;
      ext_irq_b = PIN_IDLE;
      pin_change_inputs = 8'hFF;
   end

   assign req = {irq_vec_pc_q, irq_vec_b_q, irq_vec_a_q};

   // Pins change just after an edge, like a port register would.
   task automatic drive(input logic a, input logic b, input logic [7:0] pc);
      @(posedge clk);
      ext_irq_a <= a;
      ext_irq_b <= b;
      pin_change_inputs <= pc;
   endtask : drive

   // The CPU enters a routine after the request has stood ack_dly + 3 cycles.
   // The wait restarts after each entry because the request is registered
   // and still stands for one more cycle after the flag is gone.
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         ack_vec[i] <= 1'b0;
         if (!reset_n)
         begin
            wait_q[i] <= 5'h00;
            ack_cnt[i] <= 8'h00;
         end
         else if (ack_vec[i] || !req[i] || !ack_en)
            wait_q[i] <= 5'h00;
         else if (wait_q[i] >= {1'b0, ack_dly} + 5'h02)
         begin
            ack_vec[i] <= 1'b1;
            ack_cnt[i] <= ack_cnt[i] + 8'h01;
         end
         else
            wait_q[i] <= wait_q[i] + 5'h01;
      end
   end
endmodule : epic_pin_cpu_model

// [tb/epic_ctrl_tb.sv]
// Self-checking testbench of the external pin interrupt controller.
`timescale 1ns/10ps
`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         failures++; \
         $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
      end \
   end
module epic_ctrl_tb
   import epic_pkg::*;
;
   localparam logic [7:0] F_A  = 8'h01 << BIT_A;
   localparam logic [7:0] F_B  = 8'h01 << BIT_B;
   localparam logic [7:0] F_PC = 8'h01 << BIT_PC;
   logic              clk;
   logic              reset_n;
   logic              ce;
   logic              global_int_en;
   logic              reg_wr;
   logic              reg_rd;
   logic              ack_en;
   logic [3:0]        ack_dly;
   logic              ext_irq_a;
   logic              ext_irq_b;
   logic [7:0]        pin_change_inputs;
   logic [2:0]        ack_vec;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata_q;
   logic              irq_vec_a_q;
   logic              irq_vec_b_q;
   logic              irq_vec_pc_q;
   logic [2:0]        irq;
   int                failures;
   int                num_checks;

   assign irq = {irq_vec_pc_q, irq_vec_b_q, irq_vec_a_q};

   epic_ctrl #(.PC_W(8)) u_epic_ctrl (
      .clk(clk), .reset_n(reset_n), .ce(ce), .ext_irq_a(ext_irq_a),
      .ext_irq_b(ext_irq_b), .pin_change_inputs(pin_change_inputs),
      .global_int_en(global_int_en), .ack_vec_a(ack_vec[0]),
      .ack_vec_b(ack_vec[1]), .ack_vec_pc(ack_vec[2]),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .irq_vec_a_q(irq_vec_a_q), .irq_vec_b_q(irq_vec_b_q),
      .irq_vec_pc_q(irq_vec_pc_q));

   epic_pin_cpu_model u_epic_pin_cpu_model (
      .clk(clk), .reset_n(reset_n), .ack_en(ack_en), .ack_dly(ack_dly),
      .irq_vec_a_q(irq_vec_a_q), .irq_vec_b_q(irq_vec_b_q),
      .irq_vec_pc_q(irq_vec_pc_q), .ext_irq_a(ext_irq_a),
      .ext_irq_b(ext_irq_b), .pin_change_inputs(pin_change_inputs),
      .ack_vec(ack_vec));

   // ***********************************************************
   // Bus and helper tasks.
   // ***********************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so look there.
   task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata_q, e)
   endtask : rdchk

   // ***********************************************************
   // Scenarios.
   // ***********************************************************
   task automatic t_regs;
      rdchk(OFF_GIMASK, RST_REG);
      rdchk(OFF_FLAGS, 8'h00);
      rdchk(OFF_PCMASK, 8'h00);
      rdchk(OFF_MCUCTL, 8'h00);
      wr(OFF_PCMASK, 8'hA5);
      rdchk(OFF_PCMASK, 8'hA5);
      wr(OFF_MCUCTL, 8'hFF);
      rdchk(OFF_MCUCTL, 8'h0F);
      wr(3'h5, 8'hFF);
      rdchk(3'h5, 8'h00);
      wr(OFF_FLAGS, 8'hFF);
      rdchk(OFF_FLAGS, 8'h00);
      wr(OFF_GIMASK, 8'h1F);
      rdchk(OFF_GIMASK, 8'h1F);
      wr(OFF_GIMASK, 8'h00);
      $display("test regs done");
   endtask : t_regs

   // Every edge code on both pins; requests stay off while masked.
   task automatic t_edges;
      logic [1:0] m;
      logic [7:0] fb;
      for (int p = 0; p < 2; p++)
         for (int k = 1; k < 4; k++)
         begin
            m = 2'(k);
            fb = p ? F_B : F_A;
            wr(OFF_MCUCTL, p ? 8'(m) << SNS_B_LO : 8'(m) << SNS_A_LO);
            wr(OFF_FLAGS, 8'hFF);
            u_epic_pin_cpu_model.drive(p == 0 ? 1'b0 : 1'b1,
                                       p == 0 ? 1'b1 : 1'b0, 8'hFF);
            cyc(3);
            rdchk(OFF_FLAGS, m != SENSE_RISE ? fb : 8'h00);
            wr(OFF_FLAGS, fb);
            u_epic_pin_cpu_model.drive(1'b1, 1'b1, 8'hFF);
            cyc(3);
            rdchk(OFF_FLAGS, m != SENSE_FALL ? fb : 8'h00);
            `CHK(irq, 3'b000)
         end
      $display("test edges done");
   endtask : t_edges

   // Gating by mask and global enable, exact latency, CPU entry.
   task automatic t_gate_ack;
      wr(OFF_MCUCTL, 8'(SENSE_FALL) << SNS_B_LO | 8'(SENSE_FALL));
      wr(OFF_FLAGS, 8'hFF);
      wr(OFF_GIMASK, F_B);
      u_epic_pin_cpu_model.drive(1'b1, 1'b0, 8'hFF);
      cyc(4);
      `CHK(irq, 3'b000)
      global_int_en <= 1'b1;
      cyc(2);
      #1;
      `CHK(irq, 3'b010)
      wr(OFF_GIMASK, F_A);
      cyc(1);
      #1;
      `CHK(irq, 3'b000)
      wr(OFF_GIMASK, F_A | F_B);
      u_epic_pin_cpu_model.drive(1'b0, 1'b0, 8'hFF);
      cyc(2);
      #1;
      `CHK(irq, 3'b010)
      cyc(1);
      #1;
      `CHK(irq, 3'b011)
      ack_dly <= 4'h0;
      ack_en <= 1'b1;
      cyc(8);
      #1;
      `CHK(irq, 3'b000)
      `CHK(u_epic_pin_cpu_model.ack_cnt[0], 8'h01)
      rdchk(OFF_FLAGS, 8'h00);
      ack_en <= 1'b0;
      u_epic_pin_cpu_model.drive(1'b1, 1'b1, 8'hFF);
      $display("test gate and ack done");
   endtask : t_gate_ack

   task automatic t_w1c;
      wr(OFF_GIMASK, 8'h00);
      wr(OFF_MCUCTL, 8'(SENSE_ANY) << SNS_B_LO | 8'(SENSE_ANY));
      wr(OFF_PCMASK, 8'h01);
      wr(OFF_FLAGS, 8'hFF);
      u_epic_pin_cpu_model.drive(1'b0, 1'b0, 8'hFE);
      cyc(3);
      rdchk(OFF_FLAGS, F_A | F_B | F_PC);
      wr(OFF_FLAGS, 8'h1F);
      rdchk(OFF_FLAGS, F_A | F_B | F_PC);
      wr(OFF_FLAGS, F_A);
      rdchk(OFF_FLAGS, F_B | F_PC);
      u_epic_pin_cpu_model.drive(1'b1, 1'b1, 8'hFF);
      cyc(3);
      wr(OFF_FLAGS, 8'hFF);
      $display("test write one clear done");
   endtask : t_w1c

   // Level mode: request follows the pin, CPU entry cannot stop it.
   task automatic t_level;
      wr(OFF_MCUCTL, 8'h00);
      wr(OFF_GIMASK, F_A);
      ack_dly <= 4'h1;
      ack_en <= 1'b1;
      u_epic_pin_cpu_model.drive(1'b0, 1'b1, 8'hFF);
      cyc(12);
      #1;
      `CHK(irq, 3'b001)
      rdchk(OFF_FLAGS, 8'h00);
      u_epic_pin_cpu_model.drive(1'b1, 1'b1, 8'hFF);
      cyc(3);
      #1;
      `CHK(irq, 3'b000)
      ack_en <= 1'b0;
      $display("test level done");
   endtask : t_level

   // Masked pin change bits are ignored; slow CPU entry on the third vector.
   task automatic t_pc;
      wr(OFF_MCUCTL, 8'hFF);
      wr(OFF_GIMASK, F_PC);
      u_epic_pin_cpu_model.drive(1'b1, 1'b1, 8'hFD);
      cyc(4);
      rdchk(OFF_FLAGS, 8'h00);
      u_epic_pin_cpu_model.drive(1'b1, 1'b1, 8'hFC);
      cyc(3);
      #1;
      `CHK(irq, 3'b100)
      global_int_en <= 1'b0;
      cyc(2);
      #1;
      `CHK(irq, 3'b000)
      global_int_en <= 1'b1;
      ack_dly <= 4'h5;
      ack_en <= 1'b1;
      cyc(2);
      #1;
      `CHK(irq, 3'b100)
      cyc(12);
      #1;
      `CHK(irq, 3'b000)
      `CHK(u_epic_pin_cpu_model.ack_cnt[2], 8'h01)
      ack_en <= 1'b0;
      $display("test pin change done");
   endtask : t_pc

   task automatic results;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   // ***********************************************************
   // Clock, reset, sequence and watchdog.
   // ***********************************************************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      failures = 0;
      num_checks = 0;
      reset_n = 1'b0;
      ce = 1'b1;
      global_int_en = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      ack_en = 1'b0;
      ack_dly = 4'h0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_edges();
      t_gate_ack();
      t_w1c();
      t_level();
      t_pc();
      results();
   end

   // The whole sequence takes well under a thousand cycles.
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      results();
   end
endmodule : epic_ctrl_tb
